// [src/latch_acknowledge_logic.sv]
`timescale 1ns/1ps
`default_nettype none
module latch_acknowledge_logic
    import latch_ack_pkg::*;
#(
    parameter int NLED = NUM_LED,
    parameter int NBO = NUM_BO,
    parameter int NSC = NUM_SCADA
) (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [NLED-1:0] LED_SRC,
    input wire logic [NBO-1:0] BO_SRC,
    input wire logic [NSC-1:0] SCADA_SRC,
    input wire logic TRIP_SRC,
    input wire logic [NLED-1:0] LED_ACK_INPUT,
    input wire logic [NBO-1:0] BO_ACK_INPUT,
    input wire logic TRIP_CMD_ACK_INPUT,
    input wire logic EXT_ACK_LED,
    input wire logic EXT_ACK_BO,
    input wire logic EXT_ACK_SCADA,
    input wire logic PROT_ALARM_NEW,
    input wire logic GENERAL_ALARM,
    input wire logic KEY_C_LONG,
    input wire logic COLD_START,
    input wire logic KEY_C_HELD,
    input wire logic DLG_SEL_FACTORY,
    input wire logic DLG_SEL_PASSWORD,
    input wire logic DLG_YES,
    input wire logic DLG_NO,
    input wire logic HOUR_TICK,
    output logic [NLED-1:0] LED_OUT,
    output logic [NBO-1:0] BO_OUT,
    output logic [NSC-1:0] SCADA_OUT,
    output logic TRIP_OUT,
    output logic DIALOG_ACTIVE,
    output logic DIALOG_OFFER_PASSWORD,
    output logic FACTORY_RESET,
    output logic RECORDS_CLEAR,
    output logic RESTART_REQ,
    output logic PASSWORD_RESET
);

    // --------------------------------------------------------------
    // Register state
    // --------------------------------------------------------------
    logic remote_en_q, remote_en_d;
    logic [2:0] ckey_q, ckey_d;
    logic [1:0] rstopt_q, rstopt_d;
    logic [NLED-1:0] led_en_q, led_en_d;
    logic [NLED-1:0] led_auto_q, led_auto_d;
    logic [NBO-1:0] bo_en_q, bo_en_d;
    logic [NSC-1:0] sc_en_q, sc_en_d;
    logic trip_en_q, trip_en_d;
    logic [DELAY_W-1:0] offdly_q, offdly_d;
    logic [31:0] ack_cnt_q, ack_cnt_d;
    logic [31:0] hours_q, hours_d;
    logic [31:0] prdata_q, prdata_d;
    logic [4:0] cmd_q, cmd_d;
    logic alarm_q;
    logic factory_go;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a[1:0] == 2'b00) && (a <= OFS_DIALOG);
    endfunction : is_mapped

    logic wr_acc;
    logic rd_setup;
    assign wr_acc = PSEL & PENABLE & PWRITE & is_mapped(PADDR);
    assign rd_setup = PSEL & ~PENABLE & ~PWRITE;

    latch_bus_if #(.N(NLED)) led_bus ();
    latch_bus_if #(.N(NBO)) bo_bus ();
    latch_bus_if #(.N(NSC)) sc_bus ();
    latch_bus_if #(.N(1)) trip_bus ();

    dialog_state_e dlg_q, dlg_d;

    // --------------------------------------------------------------
    // APB slave and settings
    // --------------------------------------------------------------
    always_comb begin
        remote_en_d = remote_en_q;
        ckey_d = ckey_q;
        rstopt_d = rstopt_q;
        led_en_d = led_en_q;
        led_auto_d = led_auto_q;
        bo_en_d = bo_en_q;
        sc_en_d = sc_en_q;
        trip_en_d = trip_en_q;
        offdly_d = offdly_q;
        cmd_d = '0;
        prdata_d = prdata_q;
        if (wr_acc) begin
            unique case (PADDR)
                OFS_CTRL: begin
                    remote_en_d = PWDATA[CTRL_REMOTE_BIT];
                    ckey_d = PWDATA[CTRL_CKEY_LSB +: 3];
                    rstopt_d = PWDATA[CTRL_RSTOPT_LSB +: 2];
                end
                OFS_LED_LATCH: led_en_d = PWDATA[NLED-1:0];
                OFS_LED_AUTO: led_auto_d = PWDATA[NLED-1:0];
                OFS_BO_LATCH: bo_en_d = PWDATA[NBO-1:0];
                OFS_SCADA_LATCH: sc_en_d = PWDATA[NSC-1:0];
                OFS_TRIP_LATCH: trip_en_d = PWDATA[0];
                OFS_BO_OFF_DELAY: offdly_d = PWDATA[DELAY_W-1:0];
                OFS_ACK_CMD: cmd_d = PWDATA[4:0];
                default: ;
            endcase
        end
        if (rd_setup) begin
            unique case (PADDR)
                OFS_CTRL: prdata_d = 32'({rstopt_q, ckey_q, remote_en_q});
                OFS_LED_LATCH: prdata_d = 32'(led_en_q);
                OFS_LED_AUTO: prdata_d = 32'(led_auto_q);
                OFS_BO_LATCH: prdata_d = 32'(bo_en_q);
                OFS_SCADA_LATCH: prdata_d = 32'(sc_en_q);
                OFS_TRIP_LATCH: prdata_d = 32'(trip_en_q);
                OFS_BO_OFF_DELAY: prdata_d = 32'(offdly_q);
                OFS_LED_STATE: prdata_d = 32'(led_bus.q);
                OFS_OUT_STATE: begin
                    prdata_d = '0;
                    prdata_d[NBO-1:0] = bo_bus.q;
                    prdata_d[OUT_SCADA_LSB +: NSC] = sc_bus.q;
                    prdata_d[OUT_TRIP_BIT] = trip_bus.q[0];
                end
                OFS_ACK_COUNT: prdata_d = ack_cnt_q;
                OFS_OP_HOURS: prdata_d = hours_q;
                OFS_DIALOG: prdata_d = 32'(dlg_q);
                default: prdata_d = '0;
            endcase
        end
        // Settings return to defaults; hours counter is untouched
        if (factory_go) begin
            remote_en_d = RST_REMOTE_EN;
            ckey_d = RST_CKEY;
            rstopt_d = RST_RSTOPT;
            led_en_d = '0;
            led_auto_d = '0;
            bo_en_d = '0;
            sc_en_d = '0;
            trip_en_d = 1'b0;
            offdly_d = RST_OFF_DELAY;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            remote_en_q <= RST_REMOTE_EN;
            ckey_q <= RST_CKEY;
            rstopt_q <= RST_RSTOPT;
            led_en_q <= '0;
            led_auto_q <= '0;
            bo_en_q <= '0;
            sc_en_q <= '0;
            trip_en_q <= 1'b0;
            offdly_q <= RST_OFF_DELAY;
            cmd_q <= '0;
            prdata_q <= '0;
        end else begin
            remote_en_q <= remote_en_d;
            ckey_q <= ckey_d;
            rstopt_q <= rstopt_d;
            led_en_q <= led_en_d;
            led_auto_q <= led_auto_d;
            bo_en_q <= bo_en_d;
            sc_en_q <= sc_en_d;
            trip_en_q <= trip_en_d;
            offdly_q <= offdly_d;
            cmd_q <= cmd_d;
            prdata_q <= prdata_d;
        end
    end

    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~is_mapped(PADDR);
    assign PRDATA = prdata_q;

    // --------------------------------------------------------------
    // Acknowledge sources
    // --------------------------------------------------------------
    logic alarm_edge;
    logic key_led, key_bo, key_all;
    logic col_led, col_bo, col_sc, col_trip;
    logic [NLED-1:0] led_clr;
    logic [NBO-1:0] bo_clr;
    logic [NSC-1:0] sc_clr;
    logic trip_clr;
    logic any_clr;

    always_comb begin
        // New alarm: a protection pulse or rising general alarm
        alarm_edge = PROT_ALARM_NEW | (GENERAL_ALARM & ~alarm_q);
        // Panel key works regardless of the remote setting
        key_led = KEY_C_LONG && (ckey_q != CKEY_NOTHING);
        key_bo = KEY_C_LONG
                 && (ckey_q == CKEY_LED_BO || ckey_q == CKEY_ALL);
        key_all = KEY_C_LONG && (ckey_q == CKEY_ALL);
        col_led = cmd_q[CMD_LED_BIT] | cmd_q[CMD_ALL_BIT];
        col_bo = cmd_q[CMD_BO_BIT] | cmd_q[CMD_ALL_BIT];
        col_sc = cmd_q[CMD_SCADA_BIT] | cmd_q[CMD_ALL_BIT];
        col_trip = cmd_q[CMD_TRIP_BIT] | cmd_q[CMD_ALL_BIT];
        led_clr = {NLED{key_led}};
        bo_clr = {NBO{key_bo}};
        sc_clr = {NSC{key_all}};
        trip_clr = key_all;
        if (remote_en_q) begin
            led_clr = led_clr | LED_ACK_INPUT;
            bo_clr = bo_clr | BO_ACK_INPUT;
            trip_clr = trip_clr | TRIP_CMD_ACK_INPUT;
            led_clr = led_clr | {NLED{EXT_ACK_LED | col_led}};
            bo_clr = bo_clr | {NBO{EXT_ACK_BO | col_bo}};
            sc_clr = sc_clr | {NSC{EXT_ACK_SCADA | col_sc}};
            trip_clr = trip_clr | col_trip;
            // Only LEDs take the automatic path
            led_clr = led_clr | (led_auto_q & {NLED{alarm_edge}});
        end
        any_clr = (|led_clr) | (|bo_clr) | (|sc_clr) | trip_clr;
        ack_cnt_d = ack_cnt_q + 32'(any_clr);
        if (factory_go) begin
            ack_cnt_d = '0;
        end
        hours_d = hours_q + 32'(HOUR_TICK);
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            alarm_q <= 1'b0;
            ack_cnt_q <= '0;
            hours_q <= '0;
        end else begin
            alarm_q <= GENERAL_ALARM;
            ack_cnt_q <= ack_cnt_d;
            hours_q <= hours_d;
        end
    end

    // --------------------------------------------------------------
    // Latch banks
    // --------------------------------------------------------------
    assign led_bus.src = LED_SRC;
    assign led_bus.en = led_en_q;
    assign led_bus.clr = led_clr;
    assign bo_bus.src = BO_SRC;
    assign bo_bus.en = bo_en_q;
    assign bo_bus.clr = bo_clr;
    assign sc_bus.src = SCADA_SRC;
    assign sc_bus.en = sc_en_q;
    assign sc_bus.clr = sc_clr;
    assign trip_bus.src = TRIP_SRC;
    assign trip_bus.en = trip_en_q;
    assign trip_bus.clr = trip_clr;

    latch_bank #(.N(NLED)) u_led (
        .clk(CLK_SYS),
        .rst_n(RESET_N),
        .b(led_bus)
    );

    bo_latch #(.N(NBO), .W(DELAY_W)) u_bo (
        .clk(CLK_SYS),
        .rst_n(RESET_N),
        .off_delay(offdly_q),
        .b(bo_bus)
    );

    latch_bank #(.N(NSC)) u_scada (
        .clk(CLK_SYS),
        .rst_n(RESET_N),
        .b(sc_bus)
    );

    latch_bank #(.N(1)) u_trip (
        .clk(CLK_SYS),
        .rst_n(RESET_N),
        .b(trip_bus)
    );

    assign LED_OUT = led_bus.q;
    assign BO_OUT = bo_bus.q;
    assign SCADA_OUT = sc_bus.q;
    assign TRIP_OUT = trip_bus.q[0];

    // --------------------------------------------------------------
    // Cold start reset dialog
    // --------------------------------------------------------------
    // Stepped by panel pins; the bus only sets rstopt_q, which gates entry and the password choice
    logic fact_d, fact_q, pw_d, pw_q;

    always_comb begin
        dlg_d = dlg_q;
        fact_d = 1'b0;
        pw_d = 1'b0;
        unique case (dlg_q)
            DLG_IDLE: begin
                if (COLD_START && KEY_C_HELD
                    && rstopt_q != RSTOPT_OFF) begin
                    dlg_d = DLG_MENU;
                end
            end
            DLG_MENU: begin
                if (DLG_SEL_FACTORY) begin
                    dlg_d = DLG_CONF_FACT;
                end else if (DLG_SEL_PASSWORD
                             && rstopt_q == RSTOPT_BOTH) begin
                    dlg_d = DLG_CONF_PW;
                end else if (DLG_NO) begin
                    dlg_d = DLG_IDLE;
                end
            end
            DLG_CONF_FACT: begin
                if (DLG_YES) begin
                    fact_d = 1'b1;
                    dlg_d = DLG_IDLE;
                end else if (DLG_NO) begin
                    dlg_d = DLG_MENU;
                end
            end
            DLG_CONF_PW: begin
                if (DLG_YES) begin
                    pw_d = 1'b1;
                    dlg_d = DLG_IDLE;
                end else if (DLG_NO) begin
                    dlg_d = DLG_MENU;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            dlg_q <= DLG_IDLE;
            fact_q <= 1'b0;
            pw_q <= 1'b0;
        end else begin
            dlg_q <= dlg_d;
            fact_q <= fact_d;
            pw_q <= pw_d;
        end
    end

    assign factory_go = fact_q;
    assign DIALOG_ACTIVE = (dlg_q != DLG_IDLE);
    assign DIALOG_OFFER_PASSWORD = (dlg_q != DLG_IDLE)
                                   && (rstopt_q == RSTOPT_BOTH);
    assign FACTORY_RESET = fact_q;
    assign RECORDS_CLEAR = fact_q;
    assign RESTART_REQ = fact_q;
    assign PASSWORD_RESET = pw_q;

endmodule : latch_acknowledge_logic
`default_nettype wire

// [src/latch_ack_pkg.sv]
package latch_ack_pkg;

    // --------------------------------------------------------------
    // Sizes
    // --------------------------------------------------------------
    localparam int NUM_LED = 14;
    localparam int NUM_BO = 8;
    localparam int NUM_SCADA = 8;
    localparam int DELAY_W = 16;

    // --------------------------------------------------------------
    // Register offsets (byte addresses)
    // --------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LED_LATCH = 8'h04;
    localparam logic [7:0] OFS_LED_AUTO = 8'h08;
    localparam logic [7:0] OFS_BO_LATCH = 8'h0c;
    localparam logic [7:0] OFS_SCADA_LATCH = 8'h10;
    localparam logic [7:0] OFS_TRIP_LATCH = 8'h14;
    localparam logic [7:0] OFS_BO_OFF_DELAY = 8'h18;
    localparam logic [7:0] OFS_ACK_CMD = 8'h1c;
    localparam logic [7:0] OFS_LED_STATE = 8'h20;
    localparam logic [7:0] OFS_OUT_STATE = 8'h24;
    localparam logic [7:0] OFS_ACK_COUNT = 8'h28;
    localparam logic [7:0] OFS_OP_HOURS = 8'h2c;
    localparam logic [7:0] OFS_DIALOG = 8'h30;

    // --------------------------------------------------------------
    // Control register fields
    // --------------------------------------------------------------
    localparam int CTRL_REMOTE_BIT = 0;
    localparam int CTRL_CKEY_LSB = 1;
    localparam int CTRL_RSTOPT_LSB = 4;

    // --------------------------------------------------------------
    // Collective command bits (write-one pulses)
    // --------------------------------------------------------------
    localparam int CMD_LED_BIT = 0;
    localparam int CMD_BO_BIT = 1;
    localparam int CMD_SCADA_BIT = 2;
    localparam int CMD_TRIP_BIT = 3;
    localparam int CMD_ALL_BIT = 4;

    // --------------------------------------------------------------
    // Output state packing
    // --------------------------------------------------------------
    localparam int OUT_SCADA_LSB = 8;
    localparam int OUT_TRIP_BIT = 16;

    typedef enum logic [2:0] {
        CKEY_NOTHING = 3'h0,
        CKEY_LED_NOPW = 3'h1,
        CKEY_LED = 3'h2,
        CKEY_LED_BO = 3'h3,
        CKEY_ALL = 3'h4
    } ckey_mode_e;

    typedef enum logic [1:0] {
        RSTOPT_BOTH = 2'h0,
        RSTOPT_FACTORY = 2'h1,
        RSTOPT_OFF = 2'h2
    } reset_opt_e;

    typedef enum logic [1:0] {
        DLG_IDLE = 2'b00,
        DLG_MENU = 2'b01,
        DLG_CONF_FACT = 2'b10,
        DLG_CONF_PW = 2'b11
    } dialog_state_e;

    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic RST_REMOTE_EN = 1'b1;
    localparam logic [2:0] RST_CKEY = 3'h1;
    localparam logic [1:0] RST_RSTOPT = 2'h0;
    localparam logic [DELAY_W-1:0] RST_OFF_DELAY = 16'h0000;

endpackage : latch_ack_pkg

// [src/latch_bus_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface latch_bus_if #(parameter int N = 8);
    logic [N-1:0] src;
    logic [N-1:0] en;
    logic [N-1:0] clr;
    logic [N-1:0] q;

    modport bank (input src, input en, input clr, output q);
    modport ctrl (output src, output en, output clr, input q);
endinterface : latch_bus_if
`default_nettype wire

// [src/latch_bank.sv]
`timescale 1ns/1ps
`default_nettype none
module latch_bank #(
    parameter int N = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    latch_bus_if.bank b
);
    logic [N-1:0] held_q;
    logic [N-1:0] held_d;

    // --------------------------------------------------------------
    // Set dominates clear; a live source blocks the clear
    // --------------------------------------------------------------
    always_comb begin
        held_d = b.src | (b.en & held_q & ~b.clr);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            held_q <= '0;
        end else begin
            held_q <= held_d;
        end
    end

    assign b.q = held_q;
endmodule : latch_bank
`default_nettype wire

// [src/bo_latch.sv]
`timescale 1ns/1ps
`default_nettype none
module bo_latch #(
    parameter int N = 8,
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] off_delay,
    latch_bus_if.bank b
);
    logic [N-1:0] out_q;
    logic [N-1:0] out_d;
    logic [N-1:0] pend_q;
    logic [N-1:0] pend_d;
    logic [W-1:0] tmr_q [N];
    logic [W-1:0] tmr_d [N];

    // --------------------------------------------------------------
    // Per relay off-delay timer and pending acknowledge
    // --------------------------------------------------------------
    for (genvar i = 0; i < N; i++) begin : g_bo
        logic done;
        always_comb begin
            done = (tmr_q[i] >= off_delay);
            tmr_d[i] = tmr_q[i];
            if (b.src[i]) begin
                tmr_d[i] = '0;
            end else if (!done) begin
                tmr_d[i] = tmr_q[i] + W'(1);
            end
            // Ack taken early is kept until the timer runs out
            pend_d[i] = b.en[i] & out_q[i] & ~b.src[i]
                        & (pend_q[i] | b.clr[i]);
            if (b.src[i]) begin
                out_d[i] = 1'b1;
            end else if (b.en[i]) begin
                out_d[i] = out_q[i] & ~(pend_q[i] & done);
            end else begin
                out_d[i] = out_q[i] & ~done;
            end
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                tmr_q[i] <= '0;
                out_q[i] <= 1'b0;
                pend_q[i] <= 1'b0;
            end else begin
                tmr_q[i] <= tmr_d[i];
                out_q[i] <= out_d[i];
                pend_q[i] <= pend_d[i];
            end
        end
    end

    assign b.q = out_q;
endmodule : bo_latch
`default_nettype wire

// [tb/latch_ack_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module latch_ack_chk #(
    parameter int NLED = 14
) (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PREADY,
    input wire logic [NLED-1:0] LED_SRC,
    input wire logic [NLED-1:0] LED_OUT,
    input wire logic TRIP_SRC,
    input wire logic TRIP_OUT,
    input wire logic COLD_START,
    input wire logic KEY_C_HELD,
    input wire logic DLG_YES,
    input wire logic DIALOG_ACTIVE,
    input wire logic FACTORY_RESET,
    input wire logic RECORDS_CLEAR,
    input wire logic RESTART_REQ,
    input wire logic PASSWORD_RESET
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);

    a_led_set: assert property (1'b1 |=>
        ($past(LED_SRC) & ~LED_OUT) == '0)
        else $error("LED lags its source");
    a_trip_hold: assert property (TRIP_SRC |=> TRIP_OUT)
        else $error("Trip latch cleared under active source");
    a_apb_ready: assert property (PSEL |-> PREADY)
        else $error("Slave not ready");
    a_fact_trio: assert property (FACTORY_RESET |->
        RECORDS_CLEAR && RESTART_REQ)
        else $error("Factory reset without clear and restart");
    a_fact_once: assert property (FACTORY_RESET |=> !FACTORY_RESET)
        else $error("Factory reset pulse too long");
    a_fact_cause: assert property ($rose(FACTORY_RESET) |->
        $past(DLG_YES) && $past(DIALOG_ACTIVE))
        else $error("Factory reset without confirmation");
    a_pw_cause: assert property (PASSWORD_RESET |->
        $past(DLG_YES) && !FACTORY_RESET)
        else $error("Password reset without confirmation");
    a_dlg_entry: assert property ($rose(DIALOG_ACTIVE) |->
        $past(COLD_START) && $past(KEY_C_HELD))
        else $error("Dialog opened without boot key");
endmodule : latch_ack_chk

bind latch_acknowledge_logic latch_ack_chk #(.NLED(NLED)) chk_u (
    .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .PSEL(PSEL), .PREADY(PREADY),
    .LED_SRC(LED_SRC), .LED_OUT(LED_OUT), .TRIP_SRC(TRIP_SRC),
    .TRIP_OUT(TRIP_OUT), .COLD_START(COLD_START), .KEY_C_HELD(KEY_C_HELD),
    .DLG_YES(DLG_YES), .DIALOG_ACTIVE(DIALOG_ACTIVE),
    .FACTORY_RESET(FACTORY_RESET), .RECORDS_CLEAR(RECORDS_CLEAR),
    .RESTART_REQ(RESTART_REQ), .PASSWORD_RESET(PASSWORD_RESET));
`default_nettype wire

// [tb/panel_model.sv]
`timescale 1ns/1ps
`default_nettype none
module panel_model (
    input wire logic clk,
    output logic [13:0] ev
);
    // Bits: 0-2 group acks, 3 alarm, 4 general alarm, 5 C key,
    // 6 boot, 7 key held, 8-11 dialog, 12 hour tick, 13 trip ack
    initial ev = '0;

    task automatic pulse(input logic [13:0] m);
        @(posedge clk) ev <= m;
        @(posedge clk) ev <= '0;
    endtask : pulse

    // Key must be held in the same cycle as the boot strobe
    task automatic cold_boot();
        pulse(14'h00c0);
    endtask : cold_boot
endmodule : panel_model
`default_nettype wire

// [tb/tb_latch_acknowledge_logic.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_latch_acknowledge_logic;
    import latch_ack_pkg::*;
    localparam logic [31:0] CTRL_RST =
        32'({RST_RSTOPT, RST_CKEY, RST_REMOTE_EN});
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic pready, pslverr, re;
    logic [13:0] led_src = '0, led_ack = '0, led_out, ev;
    logic [7:0] bo_src = '0, sc_src = '0, bo_ack = '0, bo_out, sc_out;
    logic trip_src = 1'b0, trip_out, dlg_act, offer_pw;
    logic fact, rec_clr, restart, password_reset_option;
    int err_count = 0, cmp_count = 0, cyc = 0, fact_n = 0, pw_n = 0;

    always #2.5 clk = ~clk;

    panel_model far_u (.clk(clk), .ev(ev));

    latch_acknowledge_logic dut_u (
        .CLK_SYS(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .LED_SRC(led_src),
        .BO_SRC(bo_src), .SCADA_SRC(sc_src), .TRIP_SRC(trip_src),
        .LED_ACK_INPUT(led_ack), .BO_ACK_INPUT(bo_ack),
        .TRIP_CMD_ACK_INPUT(ev[13]), .EXT_ACK_LED(ev[0]),
        .EXT_ACK_BO(ev[1]), .EXT_ACK_SCADA(ev[2]), .PROT_ALARM_NEW(ev[3]),
        .GENERAL_ALARM(ev[4]), .KEY_C_LONG(ev[5]), .COLD_START(ev[6]),
        .KEY_C_HELD(ev[7]), .DLG_SEL_FACTORY(ev[8]),
        .DLG_SEL_PASSWORD(ev[9]), .DLG_YES(ev[10]), .DLG_NO(ev[11]),
        .HOUR_TICK(ev[12]), .LED_OUT(led_out), .BO_OUT(bo_out),
        .SCADA_OUT(sc_out), .TRIP_OUT(trip_out), .DIALOG_ACTIVE(dlg_act),
        .DIALOG_OFFER_PASSWORD(offer_pw), .FACTORY_RESET(fact),
        .RECORDS_CLEAR(rec_clr), .RESTART_REQ(restart),
        .PASSWORD_RESET(password_reset_option));

    // One-cycle pulses are counted where they occur
    always @(posedge clk) begin
        cyc++;
        if (fact === 1'b1) fact_n++;
        if (password_reset_option === 1'b1) pw_n++;
        if (cyc == 3000) begin
            err_count++;
            summarize();
        end
    end

    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic ww(input int n);
        repeat (n) @(posedge clk);
    endtask : ww

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic blip_led(input logic [13:0] m);
        @(posedge clk) led_src <= m;
        @(posedge clk) led_src <= '0;
    endtask : blip_led

    initial begin
        ww(2);
        rst_n <= 1'b1;
        apb(0, OFS_CTRL, 0);
        chk("ctrl", CTRL_RST, rv);
        apb(0, 8'h40, 0);
        chk("unmapped err", 32'h1, re);
        chk("unmapped data", 32'h0, rv);
        apb(1, OFS_LED_LATCH, 32'h3);
        blip_led(14'h4);
        ww(2);
        chk("unlatched led", 32'h0, led_out);
        @(posedge clk) led_src <= 14'h3;
        @(posedge clk) led_src <= 14'h2;
        @(posedge clk) led_ack <= 14'h3;
        @(posedge clk) led_ack <= '0;
        ww(2);
        chk("led single ack", 32'h2, led_out);
        led_src <= '0;
        far_u.pulse(14'h1);
        ww(2);
        chk("led group ack", 32'h0, led_out);
        apb(1, OFS_CTRL, 32'h2);
        blip_led(14'h1);
        far_u.pulse(14'h1);
        ww(2);
        chk("remote off", 32'h1, led_out);
        far_u.pulse(14'h20);
        ww(2);
        chk("c key", 32'h0, led_out);
        apb(1, OFS_CTRL, 32'h3);
        apb(1, OFS_LED_AUTO, 32'h1);
        apb(1, OFS_BO_LATCH, 32'h1);
        @(posedge clk) bo_src <= 8'h1;
        blip_led(14'h1);
        bo_src <= '0;
        far_u.pulse(14'h8);
        ww(2);
        chk("auto led", 32'h0, led_out);
        chk("auto bo", 32'h1, bo_out);
        blip_led(14'h1);
        far_u.pulse(14'h10);
        ww(2);
        chk("general alarm", 32'h0, led_out);
        apb(1, OFS_BO_OFF_DELAY, 32'h8);
        @(posedge clk) bo_src <= 8'h1;
        @(posedge clk) bo_src <= 8'h0;
        apb(1, OFS_ACK_CMD, 32'h2);
        ww(2);
        chk("bo delay", 32'h1, bo_out);
        ww(8);
        chk("bo release", 32'h0, bo_out);
        apb(1, OFS_TRIP_LATCH, 32'h1);
        apb(1, OFS_SCADA_LATCH, 32'h1);
        @(posedge clk) trip_src <= 1'b1;
        sc_src <= 8'h1;
        @(posedge clk) trip_src <= 1'b0;
        sc_src <= 8'h0;
        far_u.pulse(14'h2000);
        ww(2);
        chk("trip ack", 32'h0, trip_out);
        chk("scada held", 32'h1, sc_out);
        apb(1, OFS_ACK_CMD, 32'h10);
        ww(2);
        apb(0, OFS_OUT_STATE, 0);
        chk("all cmd", 32'h0, rv);
        @(posedge clk) bo_src <= 8'h1;
        sc_src <= 8'h1;
        @(posedge clk) bo_src <= 8'h0;
        sc_src <= 8'h0;
        far_u.pulse(14'h6);
        ww(10);
        chk("group bo", 32'h0, bo_out);
        chk("group scada", 32'h0, sc_out);
        @(posedge clk) bo_src <= 8'h1;
        @(posedge clk) bo_src <= 8'h0;
        bo_ack <= 8'h1;
        @(posedge clk) bo_ack <= 8'h0;
        ww(10);
        chk("bo single ack", 32'h0, bo_out);
        apb(1, OFS_CTRL, 32'h0);
        @(posedge clk) trip_src <= 1'b1;
        sc_src <= 8'h1;
        @(posedge clk) trip_src <= 1'b0;
        sc_src <= 8'h0;
        far_u.pulse(14'h20);
        ww(2);
        apb(0, OFS_OUT_STATE, 0);
        chk("c key nothing", 32'h10100, rv);
        apb(1, OFS_CTRL, 32'h8);
        far_u.pulse(14'h20);
        ww(2);
        apb(0, OFS_OUT_STATE, 0);
        chk("c key all", 32'h0, rv);
        apb(1, OFS_CTRL, 32'h23);
        far_u.cold_boot();
        ww(1);
        chk("dialog off", 32'h0, dlg_act);
        apb(1, OFS_CTRL, 32'h3);
        far_u.cold_boot();
        ww(1);
        chk("dialog on", 32'h1, dlg_act);
        chk("offer pw", 32'h1, offer_pw);
        far_u.pulse(14'h200);
        far_u.pulse(14'h400);
        ww(2);
        chk("pw reset", 32'h1, pw_n);
        apb(1, OFS_CTRL, 32'h13);
        far_u.pulse(14'h1000);
        far_u.cold_boot();
        ww(1);
        chk("factory only", 32'h0, offer_pw);
        far_u.pulse(14'h800);
        ww(1);
        chk("dialog no", 32'h0, dlg_act);
        far_u.cold_boot();
        far_u.pulse(14'h100);
        far_u.pulse(14'h400);
        ww(2);
        chk("factory pulse", 32'h1, fact_n);
        apb(0, OFS_CTRL, 0);
        chk("ctrl restored", CTRL_RST, rv);
        apb(0, OFS_OP_HOURS, 0);
        chk("hours kept", 32'h1, rv);
        apb(0, OFS_ACK_COUNT, 0);
        chk("count cleared", 32'h0, rv);
        summarize();
    end
endmodule : tb_latch_acknowledge_logic
`default_nettype wire
